// File: tmoc_defs.svh
// Register map, bit positions and reset values of the timer mode/output/capture control
//
// Functional notes
// - Three-bit mode field, code seven prohibited
// - Software trigger acts as external trigger
// - Software trigger ignored in other modes
// - Event enable picks external edge over tick
// - Event count mode always counts external edges
// - Mode register layout, reset 00H
// - Level bit zero starts output high
// - Disabled output drives its level bit
// - Enabled output carries timer square wave
// - Level bit change moves idle pin
// - Output register layout, reset 00H
// - Edge field: none, rise, fall, both
// - Capture edge register layout, reset 00H
// - Capture only in free-run and width modes
// - Byte and single-bit register access
// - Counter enable low holds timer in reset
// - Compare match inverts enabled output
`ifndef TMOC_DEFS_SVH
`define TMOC_DEFS_SVH

`define TMOC_ADDR_MODE_CTL 32'hfffff591
`define TMOC_ADDR_OUT_CTL 32'hfffff592
`define TMOC_ADDR_CAP_EDGE 32'hfffff593

`define TMOC_RST_BYTE 8'h00
`define TMOC_RST_MODE 3'h0
`define TMOC_RST_NIB 4'h0

`define TMOC_BIT_SWTRIG 6
`define TMOC_BIT_EEE 5
`define TMOC_MODE_MSB 2
`define TMOC_MODE_LSB 0

`define TMOC_BIT_OL1 3
`define TMOC_BIT_OE1 2
`define TMOC_BIT_OL0 1
`define TMOC_BIT_OE0 0

`define TMOC_CAP1_MSB 3
`define TMOC_CAP1_LSB 2
`define TMOC_CAP0_MSB 1
`define TMOC_CAP0_LSB 0

`define TMOC_NIB_MSB 3

`endif

// File: tmoc_pkg.sv
// Types shared by the timer mode/output/capture control files
package tmoc_pkg;

    // Declaration order yields the hardware mode codes 0 to 7
    typedef enum logic [2:0] {
        TMOC_INTERVAL,
        TMOC_EXT_EVENT,
        TMOC_EXT_TRIG_PULSE,
        TMOC_ONE_SHOT,
        TMOC_PWM,
        TMOC_FREE_RUN,
        TMOC_PULSE_WIDTH,
        TMOC_PROHIBITED
    } tmoc_mode_t;

    // Declaration order yields the edge codes 00, 01, 10, 11
    typedef enum logic [1:0] {
        TMOC_EDGE_NONE,
        TMOC_EDGE_RISE,
        TMOC_EDGE_FALL,
        TMOC_EDGE_BOTH
    } tmoc_edge_t;

endpackage : tmoc_pkg

// File: tmoc_edge_sync.sv
// Pin synchroniser with rise and fall detection
`timescale 1ns/100ps
`default_nettype none

module tmoc_edge_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pin,
    output logic rise,
    output logic fall
);

    // *****************************************
    // Synchroniser and history
    // *****************************************
    logic meta;
    logic sync;
    logic prev;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    assign rise = sync & ~prev;
    assign fall = ~sync & prev;

endmodule : tmoc_edge_sync

`default_nettype wire

// File: tmoc_ctrl.sv
// Timer channel mode, output and capture edge control
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "tmoc_defs.svh"

module tmoc_ctrl #(
    parameter int ADDR_W = 32
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic bit_access,
    input wire logic [2:0] bit_index,
    output logic [7:0] reg_rdata,
    input wire logic counter_enable,
    input wire logic count_tick,
    input wire tmoc_pkg::tmoc_edge_t event_edge_sel,
    input wire tmoc_pkg::tmoc_edge_t trigger_edge_sel,
    input wire logic compare0_match,
    input wire logic compare1_match,
    input wire logic timer_in0_pin,
    input wire logic timer_in1_pin,
    output logic count_advance,
    output logic ext_trigger,
    output logic capture0,
    output logic capture1,
    output logic counter_hold,
    output logic mode_prohibited,
    output logic timer_out0_pin,
    output logic timer_out1_pin
);
    import tmoc_pkg::*;

    // *****************************************
    // Elaboration checks
    // *****************************************
    if (ADDR_W < 32) begin : g_addr_chk
        $error("ADDR_W too narrow for the register map");
    end

    // *****************************************
    // Helpers
    // *****************************************
    // Byte write, or a single bit taken from the same lane of the data
    function automatic logic [7:0] merge_wr(
        input logic [7:0] old,
        input logic [7:0] wd,
        input logic single,
        input logic [2:0] idx
    );
        logic [7:0] res;
        res = wd;
        if (single) begin
            res = old;
            res[idx] = wd[idx];
        end
        return res;
    endfunction : merge_wr

    function automatic logic [7:0] read_view(
        input logic [7:0] val,
        input logic single,
        input logic [2:0] idx
    );
        logic [7:0] res;
        res = val;
        if (single) begin
            res = 8'h00;
            res[idx] = val[idx];
        end
        return res;
    endfunction : read_view

    function automatic logic edge_hit(
        input tmoc_edge_t sel,
        input logic r,
        input logic f
    );
        logic hit;
        case (sel)
            TMOC_EDGE_RISE: hit = r;
            TMOC_EDGE_FALL: hit = f;
            TMOC_EDGE_BOTH: hit = r | f;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_hit

    // *****************************************
    // Register storage
    // *****************************************
    logic [2:0] mode_q;
    logic eee_q;
    logic [3:0] out_ctl_q;
    logic [3:0] cap_ctl_q;
    logic [7:0] mode_cur;
    logic [7:0] out_cur;
    logic [7:0] cap_cur;
    logic [7:0] next_mode_byte;
    logic [7:0] next_out_byte;
    logic [7:0] next_cap_byte;
    logic sel_mode;
    logic sel_out;
    logic sel_cap;
    tmoc_mode_t mode;

    assign sel_mode = (reg_addr == ADDR_W'(`TMOC_ADDR_MODE_CTL));
    assign sel_out = (reg_addr == ADDR_W'(`TMOC_ADDR_OUT_CTL));
    assign sel_cap = (reg_addr == ADDR_W'(`TMOC_ADDR_CAP_EDGE));
    assign mode = tmoc_mode_t'(mode_q);

    // Trigger bit is not stored, so it and the reserved bits read zero
    assign mode_cur = {1'b0, 1'b0, eee_q, 2'b00, mode_q};
    assign out_cur = {4'h0, out_ctl_q};
    assign cap_cur = {4'h0, cap_ctl_q};

    assign next_mode_byte = merge_wr(mode_cur, reg_wdata, bit_access, bit_index);
    assign next_out_byte = merge_wr(out_cur, reg_wdata, bit_access, bit_index);
    assign next_cap_byte = merge_wr(cap_cur, reg_wdata, bit_access, bit_index);

    // Software is trusted to write these only while stopped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= `TMOC_RST_MODE;
            eee_q <= 1'b0;
        end else if (reg_wr && sel_mode) begin
            mode_q <= next_mode_byte[`TMOC_MODE_MSB:`TMOC_MODE_LSB];
            eee_q <= next_mode_byte[`TMOC_BIT_EEE];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_ctl_q <= `TMOC_RST_NIB;
        end else if (reg_wr && sel_out) begin
            out_ctl_q <= next_out_byte[`TMOC_NIB_MSB:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cap_ctl_q <= `TMOC_RST_NIB;
        end else if (reg_wr && sel_cap) begin
            cap_ctl_q <= next_cap_byte[`TMOC_NIB_MSB:0];
        end
    end

    // *****************************************
    // Read port
    // *****************************************
    // Unmapped addresses and idle cycles return zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= `TMOC_RST_BYTE;
        end else if (reg_rd && sel_mode) begin
            reg_rdata <= read_view(mode_cur, bit_access, bit_index);
        end else if (reg_rd && sel_out) begin
            reg_rdata <= read_view(out_cur, bit_access, bit_index);
        end else if (reg_rd && sel_cap) begin
            reg_rdata <= read_view(cap_cur, bit_access, bit_index);
        end else begin
            reg_rdata <= `TMOC_RST_BYTE;
        end
    end

    // *****************************************
    // Input pins and edge selection
    // *****************************************
    logic rise0;
    logic fall0;
    logic rise1;
    logic fall1;

    tmoc_edge_sync u_in0 (
        .clk(clk),
        .resetn(resetn),
        .pin(timer_in0_pin),
        .rise(rise0),
        .fall(fall0)
    );

    tmoc_edge_sync u_in1 (
        .clk(clk),
        .resetn(resetn),
        .pin(timer_in1_pin),
        .rise(rise1),
        .fall(fall1)
    );

    logic event_hit;
    logic trig_hit;
    logic cap0_hit;
    logic cap1_hit;
    logic sw_trig;
    logic trig_mode;
    logic cap_mode;
    logic use_ext;

    assign event_hit = edge_hit(event_edge_sel, rise0, fall0);
    assign trig_hit = edge_hit(trigger_edge_sel, rise0, fall0);
    assign cap0_hit = edge_hit(tmoc_edge_t'(cap_ctl_q[`TMOC_CAP0_MSB:`TMOC_CAP0_LSB]),
                               rise0, fall0);
    assign cap1_hit = edge_hit(tmoc_edge_t'(cap_ctl_q[`TMOC_CAP1_MSB:`TMOC_CAP1_LSB]),
                               rise1, fall1);

    assign trig_mode = (mode == TMOC_EXT_TRIG_PULSE) || (mode == TMOC_ONE_SHOT);
    assign cap_mode = (mode == TMOC_FREE_RUN) || (mode == TMOC_PULSE_WIDTH);
    assign use_ext = eee_q || (mode == TMOC_EXT_EVENT);
    assign sw_trig = reg_wr && sel_mode && next_mode_byte[`TMOC_BIT_SWTRIG];

    // *****************************************
    // Count source, triggers and captures
    // *****************************************
    // While stopped every strobe is held off, which keeps the datapath in reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_advance <= 1'b0;
        end else begin
            count_advance <= counter_enable && (use_ext ? event_hit : count_tick);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_trigger <= 1'b0;
        end else begin
            ext_trigger <= counter_enable && trig_mode
                && (trig_hit || sw_trig);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            capture0 <= 1'b0;
            capture1 <= 1'b0;
        end else begin
            capture0 <= counter_enable && cap_mode && cap0_hit;
            capture1 <= counter_enable && cap_mode && cap1_hit;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            counter_hold <= 1'b1;
            mode_prohibited <= 1'b0;
        end else begin
            counter_hold <= !counter_enable;
            mode_prohibited <= (mode == TMOC_PROHIBITED);
        end
    end

    // *****************************************
    // Timer outputs
    // *****************************************
    logic tog0;
    logic tog1;
    logic next_tog0;
    logic next_tog1;

    assign next_tog0 = counter_enable
        && (tog0 ^ (out_ctl_q[`TMOC_BIT_OE0] && compare0_match));
    assign next_tog1 = counter_enable
        && (tog1 ^ (out_ctl_q[`TMOC_BIT_OE1] && compare1_match));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tog0 <= 1'b0;
            tog1 <= 1'b0;
        end else begin
            tog0 <= next_tog0;
            tog1 <= next_tog1;
        end
    end

    // Disabled pin follows the level bit one cycle later; an enabled pin shows its inverse while stopped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timer_out0_pin <= 1'b0;
            timer_out1_pin <= 1'b0;
        end else begin
            timer_out0_pin <= out_ctl_q[`TMOC_BIT_OE0] ?
                (~out_ctl_q[`TMOC_BIT_OL0] ^ next_tog0) :
                out_ctl_q[`TMOC_BIT_OL0];
            timer_out1_pin <= out_ctl_q[`TMOC_BIT_OE1] ?
                (~out_ctl_q[`TMOC_BIT_OL1] ^ next_tog1) :
                out_ctl_q[`TMOC_BIT_OL1];
        end
    end

    // *****************************************
    // Assertions
    // *****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    mode_code_a: assert property (
        ##1 mode_prohibited == ($past(mode) == TMOC_PROHIBITED))
        else $error("prohibited mode flag wrong");

    sw_trigger_a: assert property (
        reg_wr && sel_mode && reg_wdata[`TMOC_BIT_SWTRIG] && !bit_access
        && trig_mode && counter_enable |=> ext_trigger)
        else $error("software trigger lost");

    trig_gate_a: assert property (
        ext_trigger
        |-> $past(mode) == TMOC_EXT_TRIG_PULSE || $past(mode) == TMOC_ONE_SHOT)
        else $error("trigger outside trigger modes");

    tick_count_a: assert property (
        counter_enable && !eee_q && mode != TMOC_EXT_EVENT && count_tick
        |=> count_advance)
        else $error("internal tick not counted");

    event_mode_a: assert property (
        counter_enable && mode == TMOC_EXT_EVENT && count_tick && !event_hit
        |=> !count_advance)
        else $error("event mode counted a tick");

    mode_write_a: assert property (
        reg_wr && sel_mode && !bit_access
        |=> mode_q == $past(reg_wdata[`TMOC_MODE_MSB:`TMOC_MODE_LSB])
        && eee_q == $past(reg_wdata[`TMOC_BIT_EEE]))
        else $error("mode register write failed");

    idle_level_a: assert property (
        !out_ctl_q[`TMOC_BIT_OE0]
        |=> timer_out0_pin == $past(out_ctl_q[`TMOC_BIT_OL0]))
        else $error("idle pin level wrong");

    match_invert_a: assert property (
        counter_enable && $past(counter_enable) && out_ctl_q[`TMOC_BIT_OE0]
        && $past(out_ctl_q[`TMOC_BIT_OE0]) && $stable(out_ctl_q) && compare0_match
        |=> timer_out0_pin != $past(timer_out0_pin))
        else $error("compare match did not invert pin");

    stop_hold_a: assert property (
        !counter_enable |=> counter_hold && !count_advance && !capture0 && !capture1)
        else $error("stopped timer still active");

    capture_gate_a: assert property (
        capture0 |-> $past(cap0_hit)
        && ($past(mode) == TMOC_FREE_RUN || $past(mode) == TMOC_PULSE_WIDTH))
        else $error("capture outside capture modes");

    reserved_read_a: assert property (
        reg_rd && (sel_out || sel_cap) |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved bits read nonzero");

    sw_trig_c: cover property (sw_trig && trig_mode && counter_enable ##1 ext_trigger);
    capture_c: cover property (capture0 ##[1:20] capture1);
    toggle_c: cover property (out_ctl_q[`TMOC_BIT_OE0] && compare0_match ##1 !timer_out0_pin);
    bit_write_c: cover property (reg_wr && bit_access && sel_out);

endmodule : tmoc_ctrl

`default_nettype wire

// File: tb_timer_mode_output_capture_ctrl.sv
// Self-checking testbench of the timer mode, output and capture edge control
`timescale 1ns/100ps
`default_nettype none
`include "tmoc_defs.svh"

`define CHK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
end

module tb_timer_mode_output_capture_ctrl;
    import tmoc_pkg::*;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [31:0] reg_addr = 32'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic bit_access = 1'b0;
    logic [2:0] bit_index = 3'h0;
    logic [7:0] reg_rdata;
    logic counter_enable = 1'b0;
    logic count_tick = 1'b0;
    tmoc_edge_t event_edge_sel = TMOC_EDGE_BOTH;
    tmoc_edge_t trigger_edge_sel = TMOC_EDGE_NONE;
    logic compare0_match = 1'b0;
    logic compare1_match = 1'b0;
    logic timer_in0_pin = 1'b0;
    logic timer_in1_pin = 1'b0;
    logic count_advance, ext_trigger, capture0, capture1;
    logic counter_hold, mode_prohibited, timer_out0_pin, timer_out1_pin;
    int n_mismatch = 0;
    int tests_run = 0;
    int n_adv = 0, n_trig = 0, n_cap0 = 0, n_cap1 = 0;
    logic [7:0] q;

    tmoc_ctrl #(.ADDR_W(32)) dut_u (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .bit_access(bit_access), .bit_index(bit_index),
        .reg_rdata(reg_rdata), .counter_enable(counter_enable), .count_tick(count_tick),
        .event_edge_sel(event_edge_sel), .trigger_edge_sel(trigger_edge_sel),
        .compare0_match(compare0_match), .compare1_match(compare1_match),
        .timer_in0_pin(timer_in0_pin), .timer_in1_pin(timer_in1_pin),
        .count_advance(count_advance), .ext_trigger(ext_trigger), .capture0(capture0),
        .capture1(capture1), .counter_hold(counter_hold), .mode_prohibited(mode_prohibited),
        .timer_out0_pin(timer_out0_pin), .timer_out1_pin(timer_out1_pin)
    );

    initial begin
        forever #20 clk = ~clk;
    end

    // Strobes stand one cycle, so pulses are counted at every edge
    always @(posedge clk) begin
        if (count_advance === 1'b1) n_adv++;
        if (ext_trigger === 1'b1) n_trig++;
        if (capture0 === 1'b1) n_cap0++;
        if (capture1 === 1'b1) n_cap1++;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic clr();
        n_adv = 0;
        n_trig = 0;
        n_cap0 = 0;
        n_cap1 = 0;
    endtask : clr

    // Read data stands only in the cycle after the read strobe
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d,
                       input logic b, input logic [2:0] i, output logic [7:0] rq);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= ~w;
        reg_addr <= a;
        reg_wdata <= d;
        bit_access <= b;
        bit_index <= i;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        bit_access <= 1'b0;
        #1;
        rq = reg_rdata;
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        bus(1'b1, a, d, 1'b0, 3'h0, dummy);
    endtask : wr

    task automatic run(input logic en);
        @(posedge clk);
        counter_enable <= en;
        cyc(2);
    endtask : run

    task automatic strobe(input int which);
        @(posedge clk);
        count_tick <= (which == 0);
        compare0_match <= (which == 1);
        compare1_match <= (which == 2);
        @(posedge clk);
        count_tick <= 1'b0;
        compare0_match <= 1'b0;
        compare1_match <= 1'b0;
        cyc(3);
    endtask : strobe

    task automatic pins(input logic v);
        @(posedge clk);
        timer_in0_pin <= v;
        timer_in1_pin <= v;
        cyc(7);
    endtask : pins

    task automatic outs(input logic e0, input logic e1);
        `CHK("timer_out0_pin", e0, timer_out0_pin)
        `CHK("timer_out1_pin", e1, timer_out1_pin)
    endtask : outs

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs();
        logic [7:0] wd [3];
        logic [7:0] ex [3];
        wd = '{8'h67, 8'hff, 8'hff};
        ex = '{8'h27, 8'h0f, 8'h0f};
        for (int k = 0; k < 3; k++) begin
            bus(1'b0, `TMOC_ADDR_MODE_CTL + k, 8'h00, 1'b0, 3'h0, q);
            `CHK("reset value", 8'h00, q)
        end
        `CHK("counter_hold", 1'b1, counter_hold)
        // Mode register unused bits stay zero, the other two keep only their low four bits set
        for (int k = 0; k < 3; k++) begin
            wr(`TMOC_ADDR_MODE_CTL + k, wd[k]);
            bus(1'b0, `TMOC_ADDR_MODE_CTL + k, 8'h00, 1'b0, 3'h0, q);
            `CHK("readback", ex[k], q)
        end
        cyc(2);
        `CHK("mode_prohibited", 1'b1, mode_prohibited)
        bus(1'b1, `TMOC_ADDR_MODE_CTL, 8'h00, 1'b1, 3'h2, q);
        bus(1'b0, `TMOC_ADDR_MODE_CTL, 8'h00, 1'b1, 3'h5, q);
        `CHK("bit read 5", 8'h20, q)
        bus(1'b0, `TMOC_ADDR_MODE_CTL, 8'h00, 1'b0, 3'h0, q);
        `CHK("after bit write", 8'h23, q)
        cyc(2);
        `CHK("mode_prohibited", 1'b0, mode_prohibited)
        wr(32'hfffff594, 8'hff);
        bus(1'b0, 32'hfffff594, 8'h00, 1'b0, 3'h0, q);
        `CHK("unmapped read", 8'h00, q)
        for (int k = 0; k < 3; k++) wr(`TMOC_ADDR_MODE_CTL + k, 8'h00);
    endtask : t_regs

    task automatic t_outputs();
        wr(`TMOC_ADDR_OUT_CTL, 8'h0a);
        cyc(3);
        outs(1'b1, 1'b1);
        wr(`TMOC_ADDR_OUT_CTL, 8'h00);
        cyc(3);
        outs(1'b0, 1'b0);
        wr(`TMOC_ADDR_OUT_CTL, 8'h0f);
        cyc(3);
        outs(1'b0, 1'b0);
        wr(`TMOC_ADDR_OUT_CTL, 8'h05);
        cyc(3);
        outs(1'b1, 1'b1);
        run(1'b1);
        `CHK("counter_hold", 1'b0, counter_hold)
        strobe(1);
        outs(1'b0, 1'b1);
        strobe(2);
        outs(1'b0, 1'b0);
        run(1'b0);
        cyc(1);
        outs(1'b1, 1'b1);
        `CHK("counter_hold", 1'b1, counter_hold)
        wr(`TMOC_ADDR_OUT_CTL, 8'h02);
        run(1'b1);
        strobe(1);
        outs(1'b1, 1'b0);
        run(1'b0);
        wr(`TMOC_ADDR_OUT_CTL, 8'h00);
    endtask : t_outputs

    task automatic src(input logic [7:0] m, input int et, input int ep);
        run(1'b0);
        wr(`TMOC_ADDR_MODE_CTL, m);
        run(1'b1);
        clr();
        strobe(0);
        `CHK("tick advance", et, n_adv)
        clr();
        pins(~timer_in0_pin);
        `CHK("pin advance", ep, n_adv)
    endtask : src

    // Pin triggers ride on the same mode gate as the software trigger
    task automatic t_trig();
        @(posedge clk);
        counter_enable <= 1'b0;
        trigger_edge_sel <= TMOC_EDGE_BOTH;
        for (int m = 0; m < 7; m++) begin
            run(1'b0);
            wr(`TMOC_ADDR_MODE_CTL, m[7:0]);
            run(1'b1);
            clr();
            wr(`TMOC_ADDR_MODE_CTL, 8'h40 | m[7:0]);
            cyc(3);
            `CHK("sw trigger", int'(m == 2 || m == 3), n_trig)
            clr();
            pins(~timer_in0_pin);
            `CHK("pin trigger", int'(m == 2 || m == 3), n_trig)
        end
    endtask : t_trig

    // Mode 4 stands for every mode without capture
    task automatic t_cap();
        int e;
        for (int m = 4; m < 7; m++) begin
            for (int c = 0; c < 4; c++) begin
                run(1'b0);
                pins(1'b0);
                wr(`TMOC_ADDR_MODE_CTL, m[7:0]);
                wr(`TMOC_ADDR_CAP_EDGE, {4'h0, c[1:0], c[1:0]});
                run(1'b1);
                clr();
                pins(1'b1);
                pins(1'b0);
                e = (m >= 5) ? int'(c[0]) + int'(c[1]) : 0;
                `CHK("capture0 count", e, n_cap0)
                `CHK("capture1 count", e, n_cap1)
            end
        end
        run(1'b0);
    endtask : t_cap

    // ************************************************************
    // Run control
    // ************************************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // The scenarios need well under 20000 cycles
    initial begin
        #(40 * 20000);
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        cyc(1);
        t_regs();
        t_outputs();
        src(8'h00, 1, 0);
        src(8'h20, 0, 1);
        src(8'h01, 0, 1);
        src(8'h21, 0, 1);
        t_trig();
        t_cap();
        close_out();
    end
endmodule : tb_timer_mode_output_capture_ctrl
`default_nettype wire
